// file: verification/cmp_core_model.sv
// Behavioural model of the two analog comparator cores and their input muxes
`timescale 1ns/10ps

module cmp_core_model (
    // Clock
    input  wire logic       hclk,
    // Controls from the block
    input  wire logic [1:0] core_enable,
    input  wire logic [3:0] noninverting_select,
    // Analog condition set by the bench, 1 = positive above negative
    input  wire logic [1:0] vp_above_vn,
    // Raw core outputs
    output logic      [1:0] cmp_raw
);
    logic wobble_q = 1'b0;

    // An unpowered core has no defined output, so it must never be trusted
    always_ff @(posedge hclk) begin
        wobble_q <= !wobble_q;
    end

    // Ground on the positive input can never win the comparison
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (!core_enable[i]) begin
                cmp_raw[i] = wobble_q;
            end else if (noninverting_select[2*i+:2] == 2'b11) begin
                cmp_raw[i] = 1'b0;
            end else begin
                cmp_raw[i] = vp_above_vn[i];
            end
        end
    end
endmodule

// file: verification/cmp_ctrl_monitor.sv
// Port-level checker for the comparator control block, bound to its top module
`timescale 1ns/10ps

module cmp_ctrl_monitor (
    // Clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // Bus side
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    // Core controls and results
    input wire logic [1:0]  pin_direction_bit,
    input wire logic [1:0]  core_enable,
    input wire logic [1:0]  core_speed,
    input wire logic [1:0]  core_hysteresis,
    input wire logic [1:0]  noninverting_connect,
    input wire logic [3:0]  noninverting_select,
    input wire logic [1:0]  inverting_connect,
    input wire logic [3:0]  inverting_select,
    input wire logic [1:0]  timer_gate_out,
    input wire logic [1:0]  pwm_shutdown_src,
    input wire logic [1:0]  pin_oe_n
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic wr_dp_q;
    logic rd_dp_q;

    // Data phase trackers; a write lands only at the end of its data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_dp_q <= 1'b0;
            rd_dp_q <= 1'b0;
        end else begin
            wr_dp_q <= hsel && htrans[1] && hready && hwrite;
            rd_dp_q <= hsel && htrans[1] && hready && !hwrite;
        end
    end

    // =================================================================
    // Register-driven controls move only after a bus write
    sequence s_wrote_last;
        $past(wr_dp_q);
    endsequence

    AST_PSEL_WRITE: assert property ($changed(noninverting_select) |-> s_wrote_last)
        else $error("positive select moved without a write");
    AST_NSEL_WRITE: assert property ($changed(inverting_select) |-> s_wrote_last)
        else $error("negative select moved without a write");
    AST_ON_WRITE: assert property ($changed(core_enable) |-> s_wrote_last)
        else $error("core enable moved without a write");
    AST_SPEED_WRITE: assert property ($changed(core_speed) |-> s_wrote_last)
        else $error("speed select moved without a write");
    AST_HYST_WRITE: assert property ($changed(core_hysteresis) |-> s_wrote_last)
        else $error("hysteresis moved without a write");

    // =================================================================
    // Input connection, pin drive, shutdown and read data
    AST_CONNECT_ON: assert property ((noninverting_connect == core_enable)
        && (inverting_connect == core_enable))
        else $error("inputs connected while core off");
    AST_PIN_DRIVE: assert property ((~pin_oe_n & $past(pin_direction_bit)) == 2'h0)
        else $error("pin driven while direction is input");
    AST_SHUTDOWN_LAG: assert property (pwm_shutdown_src == $past(timer_gate_out))
        else $error("shutdown source not one cycle behind gate output");
    AST_RDATA_UPPER: assert property (hrdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    AST_RDATA_IDLE: assert property (!rd_dp_q |-> hrdata == 32'h00000000)
        else $error("read data outside a read data phase");
endmodule

bind cmp_ctrl cmp_ctrl_monitor mon_u (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
    .hrdata, .pin_direction_bit, .core_enable, .core_speed, .core_hysteresis,
    .noninverting_connect, .noninverting_select, .inverting_connect, .inverting_select,
    .timer_gate_out, .pwm_shutdown_src, .pin_oe_n);

// file: verification/test_cmp_ctrl.sv
// Self-checking bench for the comparator control block
`timescale 1ns/10ps

`include "cmp_ctrl_defines.svh"

module test_cmp_ctrl;
    logic        hclk              = 1'b0;
    logic        hresetn           = 1'b0;
    logic        hsel              = 1'b0;
    logic [31:0] haddr             = 32'h00000000;
    logic [1:0]  htrans            = 2'b00;
    logic        hwrite            = 1'b0;
    logic [2:0]  hsize             = 3'b010;
    logic [31:0] hwdata            = 32'h00000000;
    logic        timer_clk_in      = 1'b1;
    logic [1:0]  pin_direction_bit = 2'b11;
    logic [1:0]  vp                = 2'b00;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic [1:0]  cmp_raw;
    logic [1:0]  core_enable;
    logic [1:0]  core_speed;
    logic [1:0]  core_hysteresis;
    logic [1:0]  nconn;
    logic [3:0]  noninverting_select;
    logic [1:0]  iconn;
    logic [3:0]  inverting_select;
    logic [1:0]  timer_gate_out;
    logic [1:0]  pin_out;
    logic [1:0]  pin_oe_n;
    logic        irq;
    int          n_mismatch        = 0;
    int          num_checks        = 0;

    // 50 MHz clock
    always #10 hclk = !hclk;

    cmp_ctrl dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .cmp_raw(cmp_raw), .timer_clk_in(timer_clk_in),
        .pin_direction_bit(pin_direction_bit), .core_enable(core_enable),
        .core_speed(core_speed), .core_hysteresis(core_hysteresis),
        .noninverting_connect(nconn), .noninverting_select(noninverting_select),
        .inverting_connect(iconn), .inverting_select(inverting_select),
        .timer_gate_out(timer_gate_out), .pwm_shutdown_src(), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .irq(irq));

    cmp_core_model core_u (.hclk(hclk), .core_enable(core_enable),
        .noninverting_select(noninverting_select), .vp_above_vn(vp), .cmp_raw(cmp_raw));

    // =================================================================
    // Bus and comparison helpers
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Values are captured before the edge so the slave's own update cannot race
    task automatic edge_wait(output logic [7:0] rd);
        logic rdy;
        do begin
            @(negedge hclk);
            rd = hrdata[7:0];
            rdy = hreadyout;
            @(posedge hclk);
        end while (rdy !== 1'b1);
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= w;
        edge_wait(rd);
        htrans <= 2'b00;
        hwdata <= {24'h000000, d};
        edge_wait(rd);
        hsel <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] x;
        bus(1'b0, a, 8'h00, x);
        check(what, x, exp);
    endtask

    // =================================================================
    // Scenarios
    task automatic t_reset;
        rd_chk("ctrl0_c1", `OFS_CTRL0_C1, 8'h04);
        rd_chk("ctrl0_c2", `OFS_CTRL0_C2, 8'h04);
        rd_chk("ctrl1_c1", `OFS_CTRL1_C1, 8'h00);
        rd_chk("ctrl1_c2", `OFS_CTRL1_C2, 8'h00);
        rd_chk("mirror", `OFS_MIRROR, 8'h00);
        rd_chk("unmapped", 8'h20, 8'h00);
        check("hresp", 8'(hresp), 8'h00);
        check("speed_out", 8'(core_speed), 8'h03);
    endtask

    task automatic t_fields;
        wr(`OFS_CTRL0_C1, 8'hFF);
        // Freshly enabled core output needs a few cycles to reach the result bit
        repeat (8) @(posedge hclk);
        rd_chk("ctrl0_all", `OFS_CTRL0_C1, 8'hF7);
        check("core_on", 8'({core_enable[0], core_speed[0], core_hysteresis[0]}), 8'h07);
        wr(`OFS_CTRL0_C1, 8'h00);
        @(negedge hclk);
        check("core_off", 8'({core_enable[0], core_speed[0], nconn[0], iconn[0]}), 8'h00);
        for (int c = 0; c < 4; c++) begin
            wr(`OFS_CTRL1_C2, {2'b00, 2'(c), 2'b11, ~2'(c)});
            rd_chk("ctrl1_sel", `OFS_CTRL1_C2, {2'b00, 2'(c), 2'b00, ~2'(c)});
            check("psel", 8'(noninverting_select[3:2]), 8'(c));
            check("nsel", 8'(inverting_select[3:2]), {6'h00, ~2'(c)});
        end
        wr(`OFS_CTRL1_C2, 8'h00);
        wr(`OFS_MIRROR, 8'hFF);
        rd_chk("mirror_ro", `OFS_MIRROR, 8'h00);
    endtask

    // Result, polarity, mirror and pin drive of one comparator
    task automatic t_result(input int i);
        logic [7:0] a;
        a = i ? `OFS_CTRL0_C2 : `OFS_CTRL0_C1;
        vp[i] <= 1'b1;
        wr(a, 8'h80);
        repeat (8) @(posedge hclk);
        rd_chk("result", a, 8'hC0);
        rd_chk("mirror_set", `OFS_MIRROR, i ? 8'h03 : 8'h01);
        check("gate_async", 8'(timer_gate_out[i]), 8'h01);
        wr(a, 8'h90);
        repeat (8) @(posedge hclk);
        rd_chk("result_inv", a, 8'h90);
        wr(a, 8'hA0);
        pin_direction_bit[i] <= 1'b0;
        repeat (8) @(posedge hclk);
        check("pin_drive", 8'({pin_oe_n[i], pin_out[i]}), 8'h01);
        pin_direction_bit[i] <= 1'b1;
        repeat (2) @(posedge hclk);
        check("pin_release", 8'(pin_oe_n[i]), 8'h01);
    endtask

    task automatic t_irq;
        wr(`OFS_IRQ_ENABLE, 8'h03);
        wr(`OFS_IRQ_CONTROL, 8'h03);
        wr(`OFS_CTRL1_C1, 8'h80);
        vp[0] <= 1'b0;
        repeat (8) @(posedge hclk);
        wr(`OFS_IRQ_FLAG, 8'h03);
        rd_chk("no_fall_flag", `OFS_IRQ_FLAG, 8'h00);
        vp[0] <= 1'b1;
        repeat (8) @(posedge hclk);
        rd_chk("rise_flag", `OFS_IRQ_FLAG, 8'h01);
        check("irq_all_on", 8'(irq), 8'h01);
        wr(`OFS_IRQ_CONTROL, 8'h01);
        repeat (2) @(posedge hclk);
        check("irq_no_global", 8'(irq), 8'h00);
        wr(`OFS_IRQ_CONTROL, 8'h02);
        repeat (2) @(posedge hclk);
        check("irq_no_periph", 8'(irq), 8'h00);
        wr(`OFS_IRQ_CONTROL, 8'h03);
        wr(`OFS_IRQ_FLAG, 8'h01);
        repeat (2) @(posedge hclk);
        check("irq_cleared", 8'(irq), 8'h00);
        wr(`OFS_CTRL1_C1, 8'hC0);
        vp[0] <= 1'b0;
        repeat (8) @(posedge hclk);
        rd_chk("fall_flag", `OFS_IRQ_FLAG, 8'h01);
        wr(`OFS_IRQ_FLAG, 8'h01);
        wr(`OFS_CTRL0_C1, 8'h00);
        wr(`OFS_CTRL0_C1, 8'h10);
        repeat (8) @(posedge hclk);
        rd_chk("off_invert_flag", `OFS_IRQ_FLAG, 8'h01);
    endtask

    // Gate output held until the timer clock falls
    task automatic t_sync;
        wr(`OFS_CTRL0_C1, 8'h81);
        repeat (8) @(posedge hclk);
        check("gate_held", 8'(timer_gate_out[0]), 8'h01);
        timer_clk_in <= 1'b0;
        repeat (8) @(posedge hclk);
        check("gate_updated", 8'(timer_gate_out[0]), 8'h00);
        timer_clk_in <= 1'b1;
    endtask

    // =================================================================
    // Verdict, main sequence and watchdog
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset;
        t_fields;
        t_result(0);
        t_result(1);
        t_irq;
        t_sync;
        end_of_test;
    end

    // Whole run needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge hclk);
        n_mismatch++;
        end_of_test;
    end
endmodule

// file: verilog/cmp_channel.sv
// One comparator's result path, timer synchroniser and edge detectors
`timescale 1ns/10ps

`include "cmp_ctrl_defines.svh"

module cmp_channel (
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // Analog core output, asynchronous
    input  wire logic raw_in,
    // Control
    input  wire logic cmp_on,
    input  wire logic output_invert,
    input  wire logic timer_sync_enable,
    input  wire logic tclk_fall,
    // Results
    output logic      result,
    output logic      synced,
    output logic      rise,
    output logic      fall
);

    cmp_ctrl_pkg::chan_s s_q;
    cmp_ctrl_pkg::chan_s s_d;

    // Next-state logic for the whole channel
    always_comb begin
        s_d = s_q;
        // Two-stage synchroniser, first stage feeds only the second
        s_d.raw_meta = raw_in;
        s_d.raw_sync = s_q.raw_meta;
        // Off core reads as low so polarity or enable flips still move it
        s_d.result = (cmp_on & s_q.raw_sync) ^ output_invert;
        s_d.result_prev = s_q.result;
        s_d.rise = s_q.result & ~s_q.result_prev;
        s_d.fall = ~s_q.result & s_q.result_prev;
        // External copy holds between timer falling edges when synced
        if (!timer_sync_enable || tclk_fall) begin
            s_d.synced = s_q.result;
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign result = s_q.result;
    assign synced = s_q.synced;
    assign rise   = s_q.rise;
    assign fall   = s_q.fall;

endmodule

// file: verilog/cmp_ctrl.sv
// Dual comparator control block with AHB-Lite register slave
//
// The register offsets and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/10ps

`include "cmp_ctrl_defines.svh"

module cmp_ctrl #(
    parameter int NUM_CMP = 2
) (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Analog core results, asynchronous
    input  wire logic [1:0]  cmp_raw,
    // Timer clock source, asynchronous
    input  wire logic        timer_clk_in,
    // Pin direction bits, 0 selects output
    input  wire logic [1:0]  pin_direction_bit,
    // Analog core controls
    output logic [1:0]       core_enable,
    output logic [1:0]       core_speed,
    output logic [1:0]       core_hysteresis,
    output logic [1:0]       noninverting_connect,
    output logic [3:0]       noninverting_select,
    output logic [1:0]       inverting_connect,
    output logic [3:0]       inverting_select,
    // Result outputs
    output logic [1:0]       timer_gate_out,
    output logic [1:0]       pwm_shutdown_src,
    output logic [1:0]       pin_out,
    output logic [1:0]       pin_oe_n,
    // Interrupt request to the processor
    output logic             irq
);

    cmp_ctrl_pkg::top_s s_q;
    cmp_ctrl_pkg::top_s s_d;

    logic [1:0] ch_result;
    logic [1:0] ch_synced;
    logic [1:0] ch_rise;
    logic [1:0] ch_fall;

    // =================================================================
    // Comparator channels
    // =================================================================
    genvar g;
    generate
        for (g = 0; g < NUM_CMP; g++) begin : gen_ch
            cmp_channel u_ch (
                .hclk              (hclk),
                .hresetn           (hresetn),
                .raw_in            (cmp_raw[g]),
                .cmp_on            (s_q.ctrl0[g].cmp_on),
                .output_invert     (s_q.ctrl0[g].output_invert),
                .timer_sync_enable (s_q.ctrl0[g].timer_sync_enable),
                .tclk_fall         (s_q.tclk_fall),
                .result            (ch_result[g]),
                .synced            (ch_synced[g]),
                .rise              (ch_rise[g]),
                .fall              (ch_fall[g])
            );
        end
    endgenerate

    // =================================================================
    // Register image builders
    // =================================================================

    // Control 0 byte, unimplemented bit 3 reads zero
    function automatic logic [7:0] ctrl0_byte(input cmp_ctrl_pkg::ctrl0_s c,
                                              input logic res);
        logic [7:0] b;
        b = 8'h00;
        b[`C0_ON]     = c.cmp_on;
        b[`C0_RESULT] = res;
        b[`C0_PIN_OE] = c.pin_output_enable;
        b[`C0_INVERT] = c.output_invert;
        b[`C0_SPEED]  = c.speed_power_select;
        b[`C0_HYST]   = c.hysteresis_enable;
        b[`C0_SYNC]   = c.timer_sync_enable;
        return b;
    endfunction

    // Control 1 byte, bits 3-2 read zero
    function automatic logic [7:0] ctrl1_byte(input cmp_ctrl_pkg::ctrl1_s c);
        logic [7:0] b;
        b = 8'h00;
        b[`C1_RISE_EN] = c.rise_edge_irq_enable;
        b[`C1_FALL_EN] = c.fall_edge_irq_enable;
        b[`C1_PSEL_HI:`C1_PSEL_LO] = c.positive_input_select;
        b[`C1_NSEL_HI:`C1_NSEL_LO] = c.negative_input_select;
        return b;
    endfunction

    // Control 0 from a written byte; the result bit is not writable
    function automatic cmp_ctrl_pkg::ctrl0_s ctrl0_from(input logic [7:0] b);
        cmp_ctrl_pkg::ctrl0_s c;
        c.cmp_on             = b[`C0_ON];
        c.pin_output_enable  = b[`C0_PIN_OE];
        c.output_invert      = b[`C0_INVERT];
        c.speed_power_select = b[`C0_SPEED];
        c.hysteresis_enable  = b[`C0_HYST];
        c.timer_sync_enable  = b[`C0_SYNC];
        return c;
    endfunction

    // Control 1 from a written byte
    function automatic cmp_ctrl_pkg::ctrl1_s ctrl1_from(input logic [7:0] b);
        cmp_ctrl_pkg::ctrl1_s c;
        c.rise_edge_irq_enable  = b[`C1_RISE_EN];
        c.fall_edge_irq_enable  = b[`C1_FALL_EN];
        c.positive_input_select = b[`C1_PSEL_HI:`C1_PSEL_LO];
        c.negative_input_select = b[`C1_NSEL_HI:`C1_NSEL_LO];
        return c;
    endfunction

    // =================================================================
    // Next-state logic
    // =================================================================
    logic       addr_phase;
    logic [7:0] wbyte;
    logic [1:0] flag_set;
    logic [1:0] flag_clr;
    logic [7:0] rd_byte;

    // Address phase qualifier; hsize is not checked, word access assumed
    assign addr_phase = hsel & htrans[1] & hready;
    assign wbyte      = hwdata[7:0];

    // Edge events gated by their enables
    always_comb begin
        for (int i = 0; i < NUM_CMP; i++) begin
            flag_set[i] = (ch_rise[i] & s_q.ctrl1[i].rise_edge_irq_enable)
                        | (ch_fall[i] & s_q.ctrl1[i].fall_edge_irq_enable);
        end
    end

    // Write-one-to-clear of the flag register in the data phase
    always_comb begin
        flag_clr = 2'b00;
        if (s_q.dp_write && s_q.dp_addr == `OFS_IRQ_FLAG) begin
            flag_clr = wbyte[1:0];
        end
    end

    // Main state update
    always_comb begin
        s_d = s_q;

        // Timer clock passes two flops before its falling edge is found
        s_d.tclk_meta = timer_clk_in;
        s_d.tclk_sync = s_q.tclk_meta;
        s_d.tclk_prev = s_q.tclk_sync;
        s_d.tclk_fall = s_q.tclk_prev & ~s_q.tclk_sync;

        // Data phase write; unmapped or read-only addresses are ignored
        if (s_q.dp_write) begin
            case (s_q.dp_addr)
                `OFS_CTRL0_C1: begin
                    s_d.ctrl0[0] = ctrl0_from(wbyte);
                end
                `OFS_CTRL0_C2: begin
                    s_d.ctrl0[1] = ctrl0_from(wbyte);
                end
                `OFS_CTRL1_C1: begin
                    s_d.ctrl1[0] = ctrl1_from(wbyte);
                end
                `OFS_CTRL1_C2: begin
                    s_d.ctrl1[1] = ctrl1_from(wbyte);
                end
                `OFS_IRQ_ENABLE: begin
                    s_d.irq_en = wbyte[1:0];
                end
                `OFS_IRQ_CONTROL: begin
                    s_d.periph_en = wbyte[`IC_PERIPH_EN];
                    s_d.global_en = wbyte[`IC_GLOBAL_EN];
                end
                default: begin
                    s_d.flag = s_q.flag;
                end
            endcase
        end

        // A new event in the clearing cycle keeps the flag set
        s_d.flag = (s_q.flag & ~flag_clr) | flag_set;

        // Request only when every enable level agrees
        s_d.irq = (|(s_q.flag & s_q.irq_en)) & s_q.periph_en & s_q.global_en;

        // Capture the next address phase
        s_d.dp_write = addr_phase & hwrite;
        s_d.dp_addr  = haddr[7:0];
        s_d.ready    = 1'b1;

        // Read data built from updated state so a just-written value shows
        rd_byte = 8'h00;
        if (addr_phase && !hwrite) begin
            case (haddr[7:0])
                `OFS_CTRL0_C1: begin
                    rd_byte = ctrl0_byte(s_d.ctrl0[0], ch_result[0]);
                end
                `OFS_CTRL0_C2: begin
                    rd_byte = ctrl0_byte(s_d.ctrl0[1], ch_result[1]);
                end
                `OFS_CTRL1_C1: begin
                    rd_byte = ctrl1_byte(s_d.ctrl1[0]);
                end
                `OFS_CTRL1_C2: begin
                    rd_byte = ctrl1_byte(s_d.ctrl1[1]);
                end
                `OFS_MIRROR: begin
                    rd_byte = {6'h00, ch_result[1], ch_result[0]};
                end
                `OFS_IRQ_FLAG: begin
                    rd_byte = {6'h00, s_d.flag};
                end
                `OFS_IRQ_ENABLE: begin
                    rd_byte = {6'h00, s_d.irq_en};
                end
                `OFS_IRQ_CONTROL: begin
                    rd_byte = {6'h00, s_d.global_en, s_d.periph_en};
                end
                default: begin
                    rd_byte = 8'h00;
                end
            endcase
        end
        s_d.rdata = {24'h000000, rd_byte};

        // Pin follows the timer-aligned result; direction must be output
        for (int i = 0; i < NUM_CMP; i++) begin
            s_d.pin_value[i] = ch_synced[i];
            s_d.pin_oe_n[i]  = ~(s_d.ctrl0[i].pin_output_enable
                               & ~pin_direction_bit[i]);
            s_d.shutdown[i]  = ch_synced[i];
        end
    end

    // =================================================================
    // State register
    // =================================================================
    // Reset leaves speed select high and every pin undriven
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q          <= '0;
            s_q.ctrl0[0] <= ctrl0_from(`RST_CTRL0);
            s_q.ctrl0[1] <= ctrl0_from(`RST_CTRL0);
            s_q.ready    <= 1'b1;
            s_q.pin_oe_n <= 2'b11;
        end else begin
            s_q <= s_d;
        end
    end

    // =================================================================
    // Outputs, straight from flops except hresp, which is tied low
    // =================================================================
    assign hreadyout = s_q.ready;
    assign hresp     = 1'b0;
    assign hrdata    = s_q.rdata;
    assign irq       = s_q.irq;

    // Analog core controls; inputs open whenever the comparator is off
    always_comb begin
        for (int i = 0; i < NUM_CMP; i++) begin
            core_enable[i]          = s_q.ctrl0[i].cmp_on;
            core_speed[i]           = s_q.ctrl0[i].speed_power_select;
            core_hysteresis[i]      = s_q.ctrl0[i].hysteresis_enable;
            noninverting_connect[i] = s_q.ctrl0[i].cmp_on;
            inverting_connect[i]    = s_q.ctrl0[i].cmp_on;
            noninverting_select[2*i +: 2] = s_q.ctrl1[i].positive_input_select;
            inverting_select[2*i +: 2]    = s_q.ctrl1[i].negative_input_select;
        end
    end

    assign timer_gate_out   = ch_synced;
    assign pwm_shutdown_src = s_q.shutdown;
    assign pin_out          = s_q.pin_value;
    assign pin_oe_n         = s_q.pin_oe_n;

endmodule

// file: verilog/cmp_ctrl_defines.svh
// Offsets, field positions, reset values for the comparator control block
`ifndef CMP_CTRL_DEFINES_SVH
`define CMP_CTRL_DEFINES_SVH

// =====================================================================
// Register byte offsets
`define OFS_CTRL0_C1      8'h00
`define OFS_CTRL0_C2      8'h04
`define OFS_CTRL1_C1      8'h08
`define OFS_CTRL1_C2      8'h0C
`define OFS_MIRROR        8'h10
`define OFS_IRQ_FLAG      8'h14
`define OFS_IRQ_ENABLE    8'h18
`define OFS_IRQ_CONTROL   8'h1C

// =====================================================================
// Control register 0 fields
`define C0_ON             7
`define C0_RESULT         6
`define C0_PIN_OE         5
`define C0_INVERT         4
`define C0_SPEED          2
`define C0_HYST           1
`define C0_SYNC           0

// =====================================================================
// Control register 1 fields
`define C1_RISE_EN        7
`define C1_FALL_EN        6
`define C1_PSEL_HI        5
`define C1_PSEL_LO        4
`define C1_NSEL_HI        1
`define C1_NSEL_LO        0

// =====================================================================
// Interrupt control fields
`define IC_PERIPH_EN      0
`define IC_GLOBAL_EN      1

// =====================================================================
// Reset values
`define RST_CTRL0         8'h04
`define RST_CTRL1         8'h00

`endif

// file: verilog/cmp_ctrl_pkg.sv
// Types shared by the comparator control block
package cmp_ctrl_pkg;

    // =================================================================
    // Control register 0 image, result bit excluded
    typedef struct packed {
        logic cmp_on;
        logic pin_output_enable;
        logic output_invert;
        logic speed_power_select;
        logic hysteresis_enable;
        logic timer_sync_enable;
    } ctrl0_s;

    // =================================================================
    // Control register 1 image
    typedef struct packed {
        logic       rise_edge_irq_enable;
        logic       fall_edge_irq_enable;
        logic [1:0] positive_input_select;
        logic [1:0] negative_input_select;
    } ctrl1_s;

    // =================================================================
    // Per-comparator channel state
    typedef struct packed {
        logic raw_meta;
        logic raw_sync;
        logic result;
        logic result_prev;
        logic synced;
        logic rise;
        logic fall;
    } chan_s;

    // =================================================================
    // Top-level state
    typedef struct packed {
        ctrl0_s [1:0] ctrl0;
        ctrl1_s [1:0] ctrl1;
        logic   [1:0] flag;
        logic   [1:0] irq_en;
        logic         periph_en;
        logic         global_en;
        logic         dp_write;
        logic   [7:0] dp_addr;
        logic  [31:0] rdata;
        logic         ready;
        logic         irq;
        logic         tclk_meta;
        logic         tclk_sync;
        logic         tclk_prev;
        logic         tclk_fall;
        logic   [1:0] pin_value;
        logic   [1:0] pin_oe_n;
        logic   [1:0] shutdown;
    } top_s;

endpackage
